// ### hw/twm_wave_ctrl.sv
// Waveform mode control of a 16-bit timer: control register, counter sequence and three compare pins
//
// How it works
// - Nonzero output field hands the pin to the channel, except in mode 13 or for a forbidden toggle; driver follows direction bit.
// - Output field meaning depends on non-PWM, fast PWM or dual-slope family.
// - Non-PWM: 0 disconnects, 1 toggles, 2 clears, 3 sets on match.
// - Fast PWM value 1 toggles channel A only in mode 15.
// - Fast PWM value 2 clears on match, sets at BOTTOM.
// - Fast PWM value 3 sets on match, clears at BOTTOM.
// - Fast PWM values 2 and 3 with compare equal TOP ignore match; action only at BOTTOM.
// - Dual-slope value 1 toggles channel A only in modes 9 or 11.
// - Dual-slope value 2 clears on up-count match, sets on down-count match.
// - Dual-slope value 3 sets on up-count match, clears on down-count match.
// - Mode is two register bits plus two high bits; mode 13 reserved.
// - Modes 0, 4, 12: free or clear-on-match, immediate update, flag at MAX.
// - Phase modes 1-3, 10, 11: update at TOP, flag at BOTTOM.
// - Modes 8 and 9: update and flag both at BOTTOM.
// - Fast modes 5-7, 14, 15: update at BOTTOM, flag at TOP.
// - Dual-slope counter runs up from zero to TOP and back down.
`timescale 1ns/10ps
`include "twm_map.svh"

module twm_wave_ctrl (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // I/O register port
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Neighbouring registers and timer clock enable
  input wire logic [1:0] wave_mode_high_bits_i,
  input wire logic timer_tick_i,
  input wire logic [15:0] compare_buf_a_i,
  input wire logic [15:0] compare_buf_b_i,
  input wire logic [15:0] compare_buf_c_i,
  input wire logic [15:0] capture_value_i,
  // Port logic for pins A, B, C (bit 0 is A)
  input wire logic [2:0] port_data_i,
  input wire logic [2:0] port_dir_i,
  // Pins A, B, C
  output logic [2:0] wave_pin_o,
  output logic [2:0] wave_pin_oe_o,
  // Timer state
  output logic [15:0] count_value_o,
  output logic count_up_o,
  output logic overflow_flag_o
);

  logic [7:0] ctrl_a_ff;
  logic [7:0] rdata_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic up_ff;
  logic nxt_up;
  logic ovf_ff;
  logic [2:0] pin_ff;
  logic [15:0] cmp_ff [3];
  logic [15:0] cmp_buf [3];
  logic [1:0] out_mode [3];
  logic [2:0] oc_w;
  logic [2:0] match_w;
  logic [2:0] tog_ok_w;
  logic [2:0] ovr_w;
  logic [3:0] wave_mode_field;
  twm_pkg::twm_dec_s dec_w;
  logic [15:0] top_val;
  logic at_top;
  logic at_bot;
  logic at_max;
  logic dual;
  logic wr_hit;
  logic rd_hit;
  logic upd_now;
  logic ovf_evt;

  // Fixed TOP for the 8, 9 and 10 bit modes, picked by the two low mode bits
  function automatic logic [15:0] fixed_top(input logic [1:0] low);
    case (low)
      2'h1: fixed_top = `TWM_TOP_8BIT;
      2'h2: fixed_top = `TWM_TOP_9BIT;
      2'h3: fixed_top = `TWM_TOP_10BIT;
      default: fixed_top = `TWM_MAX;
    endcase
  endfunction : fixed_top

  // Mode table: family, TOP source, compare update point, overflow point
  function automatic twm_pkg::twm_dec_s dec_mode(input logic [3:0] m);
    twm_pkg::twm_dec_s d;
    d.fam = twm_pkg::FAM_RSVD;
    d.top_src = twm_pkg::TOP_FIXED;
    d.upd_pt = twm_pkg::PT_IMMEDIATE;
    d.ovf_pt = twm_pkg::PT_MAX;
    d.fixed_top = `TWM_MAX;
    case (m)
      `TWM_MODE_NORMAL: d.fam = twm_pkg::FAM_NORMAL;
      `TWM_MODE_CTC_OCA: begin
        d.fam = twm_pkg::FAM_CTC;
        d.top_src = twm_pkg::TOP_CMP_A;
      end
      `TWM_MODE_CTC_ICR: begin
        d.fam = twm_pkg::FAM_CTC;
        d.top_src = twm_pkg::TOP_CAPTURE;
      end
      `TWM_MODE_PC8, `TWM_MODE_PC9, `TWM_MODE_PC10, `TWM_MODE_PC_ICR, `TWM_MODE_PC_OCA: begin
        d.fam = twm_pkg::FAM_PHASE;
        d.upd_pt = twm_pkg::PT_TOP;
        d.ovf_pt = twm_pkg::PT_BOTTOM;
        d.fixed_top = fixed_top(m[1:0]);
        d.top_src = !m[3] ? twm_pkg::TOP_FIXED : (m[0] ? twm_pkg::TOP_CMP_A : twm_pkg::TOP_CAPTURE);
      end
      `TWM_MODE_PFC_ICR, `TWM_MODE_PFC_OCA: begin
        d.fam = twm_pkg::FAM_PFC;
        d.upd_pt = twm_pkg::PT_BOTTOM;
        d.ovf_pt = twm_pkg::PT_BOTTOM;
        d.top_src = m[0] ? twm_pkg::TOP_CMP_A : twm_pkg::TOP_CAPTURE;
      end
      `TWM_MODE_FAST8, `TWM_MODE_FAST9, `TWM_MODE_FAST10, `TWM_MODE_FAST_ICR, `TWM_MODE_FAST_OCA: begin
        d.fam = twm_pkg::FAM_FAST;
        d.upd_pt = twm_pkg::PT_BOTTOM;
        d.ovf_pt = twm_pkg::PT_TOP;
        d.fixed_top = fixed_top(m[1:0]);
        d.top_src = !m[3] ? twm_pkg::TOP_FIXED : (m[0] ? twm_pkg::TOP_CMP_A : twm_pkg::TOP_CAPTURE);
      end
      default: d.fam = twm_pkg::FAM_RSVD;
    endcase
    dec_mode = d;
  endfunction : dec_mode

  // Register decode; the register is the only address this block answers
  assign wr_hit = io_wr_i && (io_addr_i == `TWM_CTRL_A_ADDR);
  assign rd_hit = io_rd_i && (io_addr_i == `TWM_CTRL_A_ADDR);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_a_ff <= `TWM_CTRL_A_RST;
      rdata_ff <= 8'h00;
    end else begin
      if (wr_hit) begin
        ctrl_a_ff <= io_wdata_i;
      end
      rdata_ff <= rd_hit ? ctrl_a_ff : 8'h00;
    end
  end

  assign io_rdata_o = rdata_ff;

  // mode from high bits and register low bits
  assign wave_mode_field = {wave_mode_high_bits_i, ctrl_a_ff[`TWM_WAVE_LOW_HI:`TWM_WAVE_LOW_LO]};
  assign dec_w = dec_mode(wave_mode_field);
  assign out_mode[0] = ctrl_a_ff[`TWM_CHAN_A_MODE_HI:`TWM_CHAN_A_MODE_LO];
  assign out_mode[1] = ctrl_a_ff[`TWM_CHAN_B_MODE_HI:`TWM_CHAN_B_MODE_LO];
  assign out_mode[2] = ctrl_a_ff[`TWM_CHAN_C_MODE_HI:`TWM_CHAN_C_MODE_LO];
  assign cmp_buf[0] = compare_buf_a_i;
  assign cmp_buf[1] = compare_buf_b_i;
  assign cmp_buf[2] = compare_buf_c_i;

  // TOP selection and counter landmarks
  assign top_val = (dec_w.top_src == twm_pkg::TOP_CMP_A) ? cmp_ff[0] :
                   (dec_w.top_src == twm_pkg::TOP_CAPTURE) ? capture_value_i : dec_w.fixed_top;
  assign at_top = (cnt_ff == top_val);
  assign at_bot = (cnt_ff == `TWM_BOTTOM);
  assign at_max = (cnt_ff == `TWM_MAX);
  assign dual = (dec_w.fam == twm_pkg::FAM_PHASE) || (dec_w.fam == twm_pkg::FAM_PFC);

  // Next count and direction; the reserved mode holds the counter
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_up = up_ff;
    if (timer_tick_i) begin
      case (dec_w.fam)
        twm_pkg::FAM_NORMAL: begin
          nxt_cnt = cnt_ff + 16'h0001;
          nxt_up = 1'b1;
        end
        twm_pkg::FAM_CTC, twm_pkg::FAM_FAST: begin
          nxt_cnt = at_top ? `TWM_BOTTOM : cnt_ff + 16'h0001;
          nxt_up = 1'b1;
        end
        twm_pkg::FAM_PHASE, twm_pkg::FAM_PFC: begin
          // turn at TOP and at BOTTOM
          if (up_ff && at_top) begin
            nxt_up = 1'b0;
            nxt_cnt = cnt_ff - 16'h0001;
          end else if (!up_ff && at_bot) begin
            nxt_up = 1'b1;
            nxt_cnt = cnt_ff + 16'h0001;
          end else begin
            nxt_cnt = up_ff ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
          end
        end
        default: nxt_cnt = cnt_ff;
      endcase
    end
  end

  // Compare update point and overflow event
  assign upd_now = (dec_w.upd_pt == twm_pkg::PT_IMMEDIATE) ||
                   (timer_tick_i && (dec_w.upd_pt == twm_pkg::PT_TOP) && at_top && up_ff) ||
                   (timer_tick_i && (dec_w.upd_pt == twm_pkg::PT_BOTTOM) && at_bot);
  assign ovf_evt = timer_tick_i && (dec_w.fam != twm_pkg::FAM_RSVD) &&
                   (((dec_w.ovf_pt == twm_pkg::PT_MAX) && at_max) ||
                    ((dec_w.ovf_pt == twm_pkg::PT_TOP) && at_top) ||
                    ((dec_w.ovf_pt == twm_pkg::PT_BOTTOM) && at_bot && dual));

  // Counter, direction and overflow pulse
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= `TWM_BOTTOM;
      up_ff <= 1'b1;
      ovf_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      up_ff <= nxt_up;
      ovf_ff <= ovf_evt;
    end
  end

  assign count_value_o = cnt_ff;
  assign count_up_o = up_ff;
  assign overflow_flag_o = ovf_ff;

  // Per channel: active compare value, match, toggle permission, pin takeover
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      // Buffered compare value; double buffering hides glitches in PWM modes
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          cmp_ff[gi] <= `TWM_BOTTOM;
        end else if (upd_now) begin
          cmp_ff[gi] <= cmp_buf[gi];
        end
      end

      assign match_w[gi] = timer_tick_i && (cnt_ff == cmp_ff[gi]);

      // toggle allowed for every channel in non-PWM modes, otherwise only for channel A in modes 15, 9, 11
      assign tog_ok_w[gi] = (dec_w.fam == twm_pkg::FAM_NORMAL) || (dec_w.fam == twm_pkg::FAM_CTC) ||
                            ((gi == 0) && ((wave_mode_field == `TWM_MODE_FAST_OCA) ||
                             (wave_mode_field == `TWM_MODE_PFC_OCA) || (wave_mode_field == `TWM_MODE_PC_OCA)));

      // takeover unless the reserved mode or a forbidden toggle leaves the pin disconnected
      assign ovr_w[gi] = (out_mode[gi] != `TWM_OUT_OFF) && (dec_w.fam != twm_pkg::FAM_RSVD) &&
                         !((out_mode[gi] == `TWM_OUT_TOGGLE) && !tog_ok_w[gi]);

      twm_chan_out u_chan (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .fam_i(dec_w.fam),
        .out_mode_i(out_mode[gi]),
        .toggle_ok_i(tog_ok_w[gi]),
        .match_i(match_w[gi]),
        .bottom_i(timer_tick_i && at_bot),
        .count_up_i(up_ff),
        .cmp_is_top_i(cmp_ff[gi] == top_val),
        .oc_o(oc_w[gi])
      );
    end
  endgenerate

  // pin value registered; driver enable follows the direction bits
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_ff <= 3'h0;
    end else begin
      pin_ff <= (ovr_w & oc_w) | (~ovr_w & port_data_i);
    end
  end

  assign wave_pin_o = pin_ff;
  assign wave_pin_oe_o = port_dir_i;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_port_pass;
    !rst_i && (out_mode[0] == `TWM_OUT_OFF) |=> (wave_pin_o[0] == $past(port_data_i[0]));
  endproperty
  a_port_pass: assert property (p_port_pass) else $error("pin A not port data while disconnected");

  property p_free_wrap;
    (wave_mode_field == `TWM_MODE_NORMAL) && timer_tick_i && at_max |=> (cnt_ff == `TWM_BOTTOM) && overflow_flag_o;
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("normal mode wrap or flag wrong");

  property p_fast_top;
    (dec_w.fam == twm_pkg::FAM_FAST) && timer_tick_i && at_top |=> (cnt_ff == `TWM_BOTTOM) && overflow_flag_o;
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("fast mode TOP restart or flag wrong");

  property p_turn_down;
    dual && timer_tick_i && up_ff && at_top && !at_bot |=> !up_ff && (cnt_ff == $past(cnt_ff) - 16'h0001);
  endproperty
  a_turn_down: assert property (p_turn_down) else $error("dual slope did not turn at TOP");

  property p_pfc_update;
    !rst_i && (dec_w.fam == twm_pkg::FAM_PFC) && timer_tick_i && at_bot |=> (cmp_ff[1] == $past(compare_buf_b_i));
  endproperty
  a_pfc_update: assert property (p_pfc_update) else $error("compare not updated at BOTTOM");

  property p_pc8_turn;
    (wave_mode_field == `TWM_MODE_PC8) && timer_tick_i && up_ff && (cnt_ff == `TWM_TOP_8BIT)
      |=> (cnt_ff == 16'h00FE) ##1 !overflow_flag_o;
  endproperty
  a_pc8_turn: assert property (p_pc8_turn) else $error("phase 8-bit TOP wrong");

  property p_fast_clear;
    (dec_w.fam == twm_pkg::FAM_FAST) && (out_mode[1] == `TWM_OUT_CLEAR) && match_w[1] && (cmp_ff[1] != top_val)
      |=> !oc_w[1];
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("fast non-inverting match did not clear");

  property p_dual_up_clear;
    dual && (out_mode[2] == `TWM_OUT_CLEAR) && match_w[2] && up_ff |=> !oc_w[2];
  endproperty
  a_dual_up_clear: assert property (p_dual_up_clear) else $error("dual slope up match did not clear");

  property p_toggle;
    (dec_w.fam == twm_pkg::FAM_NORMAL) && (out_mode[1] == `TWM_OUT_TOGGLE) && match_w[1] |=> (oc_w[1] != $past(oc_w[1]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("non-PWM toggle missing");

endmodule : twm_wave_ctrl

// ### hw/twm_map.svh
// Register address, field positions, reset values and count limits of the waveform mode control
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH

// First control register in I/O space
`define TWM_CTRL_A_ADDR 8'h8B
`define TWM_CTRL_A_RST 8'h00

// Field positions inside the first control register
`define TWM_CHAN_A_MODE_HI 7
`define TWM_CHAN_A_MODE_LO 6
`define TWM_CHAN_B_MODE_HI 5
`define TWM_CHAN_B_MODE_LO 4
`define TWM_CHAN_C_MODE_HI 3
`define TWM_CHAN_C_MODE_LO 2
`define TWM_WAVE_LOW_HI 1
`define TWM_WAVE_LOW_LO 0

// Waveform mode codes
`define TWM_MODE_NORMAL 4'h0
`define TWM_MODE_PC8 4'h1
`define TWM_MODE_PC9 4'h2
`define TWM_MODE_PC10 4'h3
`define TWM_MODE_CTC_OCA 4'h4
`define TWM_MODE_FAST8 4'h5
`define TWM_MODE_FAST9 4'h6
`define TWM_MODE_FAST10 4'h7
`define TWM_MODE_PFC_ICR 4'h8
`define TWM_MODE_PFC_OCA 4'h9
`define TWM_MODE_PC_ICR 4'hA
`define TWM_MODE_PC_OCA 4'hB
`define TWM_MODE_CTC_ICR 4'hC
`define TWM_MODE_RSVD 4'hD
`define TWM_MODE_FAST_ICR 4'hE
`define TWM_MODE_FAST_OCA 4'hF

// Output mode field codes
`define TWM_OUT_OFF 2'h0
`define TWM_OUT_TOGGLE 2'h1
`define TWM_OUT_CLEAR 2'h2
`define TWM_OUT_SET 2'h3

// Counter limits
`define TWM_BOTTOM 16'h0000
`define TWM_MAX 16'hFFFF
`define TWM_TOP_8BIT 16'h00FF
`define TWM_TOP_9BIT 16'h01FF
`define TWM_TOP_10BIT 16'h03FF

`endif

// ### hw/twm_pkg.sv
// Types shared by the waveform mode control files
package twm_pkg;

  // Counting family of a waveform mode
  typedef enum logic [2:0] {FAM_NORMAL, FAM_CTC, FAM_FAST, FAM_PHASE, FAM_PFC, FAM_RSVD} twm_fam_e;

  // Source of the TOP value
  typedef enum logic [1:0] {TOP_FIXED, TOP_CMP_A, TOP_CAPTURE} twm_top_e;

  // Point at which a compare value or the overflow flag takes effect
  typedef enum logic [1:0] {PT_IMMEDIATE, PT_MAX, PT_TOP, PT_BOTTOM} twm_point_e;

  // Decoded waveform mode
  typedef struct packed {
    twm_fam_e fam;
    twm_top_e top_src;
    twm_point_e upd_pt;
    twm_point_e ovf_pt;
    logic [15:0] fixed_top;
  } twm_dec_s;

endpackage : twm_pkg

// ### hw/twm_chan_out.sv
// One compare output channel: holds the waveform output bit and applies match and BOTTOM events
`timescale 1ns/10ps
`include "twm_map.svh"

module twm_chan_out (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Mode and events
  input twm_pkg::twm_fam_e fam_i,
  input wire logic [1:0] out_mode_i,
  input wire logic toggle_ok_i,
  input wire logic match_i,
  input wire logic bottom_i,
  input wire logic count_up_i,
  input wire logic cmp_is_top_i,
  // Waveform output bit
  output logic oc_o
);

  logic oc_ff;
  logic nxt_oc;
  logic is_toggle;
  logic fast_match;

  assign is_toggle = (out_mode_i == `TWM_OUT_TOGGLE) && toggle_ok_i;
  assign fast_match = match_i && !(cmp_is_top_i && out_mode_i[1]);

  // Next output value per counting family
  always_comb begin
    nxt_oc = oc_ff;
    case (fam_i)
      twm_pkg::FAM_NORMAL, twm_pkg::FAM_CTC: begin
        if (match_i) begin
          case (out_mode_i)
            `TWM_OUT_TOGGLE: nxt_oc = ~oc_ff;
            `TWM_OUT_CLEAR: nxt_oc = 1'b0;
            `TWM_OUT_SET: nxt_oc = 1'b1;
            default: nxt_oc = oc_ff;
          endcase
        end
      end
      twm_pkg::FAM_FAST: begin
        if (is_toggle && match_i) begin
          nxt_oc = ~oc_ff;
        end else if (out_mode_i[1]) begin
          // BOTTOM restores, match wins when both fall together
          if (fast_match) begin
            nxt_oc = out_mode_i[0];
          end else if (bottom_i) begin
            nxt_oc = ~out_mode_i[0];
          end
        end
      end
      twm_pkg::FAM_PHASE, twm_pkg::FAM_PFC: begin
        if (is_toggle && match_i) begin
          nxt_oc = ~oc_ff;
        end else if (out_mode_i[1] && match_i) begin
          nxt_oc = count_up_i ? out_mode_i[0] : ~out_mode_i[0];
        end
      end
      default: nxt_oc = oc_ff;
    endcase
  end

  // Output bit register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_ff <= 1'b0;
    end else begin
      oc_ff <= nxt_oc;
    end
  end

  assign oc_o = oc_ff;

endmodule : twm_chan_out

// ### tb/twm_pin_load.sv
// External circuitry on the three waveform pins, with pull-downs on each line
`timescale 1ns/10ps

module twm_pin_load (
  // Pin values and driver enables from the timer
  input wire logic [2:0] pin_i,
  input wire logic [2:0] oe_i,
  // Levels seen by the load
  output logic [2:0] level_o
);
  // A pin whose driver is off falls to its pull-down, never keeps the last value
  assign level_o = pin_i & oe_i;
endmodule : twm_pin_load

// ### tb/twm_wave_ctrl_tb.sv
// Self-checking bench of the waveform mode control
`timescale 1ns/10ps
`include "twm_map.svh"

module twm_wave_ctrl_tb;
  // Stimulus
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [1:0] hib = 2'h0;
  logic tick = 1'b1;
  logic [15:0] cmp_a = 16'h0040;
  logic [15:0] cmp_b = 16'h0040;
  logic [15:0] cmp_c = 16'h0040;
  logic [15:0] cap = 16'h0100;
  logic [2:0] pdata = 3'h0;
  logic [2:0] pdir = 3'h7;
  // Observed
  logic [7:0] rdata;
  logic [2:0] pin;
  logic [2:0] oe;
  logic [2:0] lvl;
  logic [15:0] cnt;
  logic up;
  logic ovf;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;

  twm_wave_ctrl u_twm_wave_ctrl (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
    .io_wdata_i(wdata), .io_rdata_o(rdata), .wave_mode_high_bits_i(hib), .timer_tick_i(tick),
    .compare_buf_a_i(cmp_a), .compare_buf_b_i(cmp_b), .compare_buf_c_i(cmp_c), .capture_value_i(cap),
    .port_data_i(pdata), .port_dir_i(pdir), .wave_pin_o(pin), .wave_pin_oe_o(oe),
    .count_value_o(cnt), .count_up_o(up), .overflow_flag_o(ovf)
  );

  twm_pin_load u_twm_pin_load (.pin_i(pin), .oe_i(oe), .level_o(lvl));

  // Free-running 40 MHz clock
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Hang guard; the normal-mode run through MAX alone takes about 65536 cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk

  // One write strobe, taken at the edge after it is raised
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stands for the one cycle after the taking edge
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    @(negedge core_clk_i);
    d = rdata;
  endtask : reg_rd

  task automatic wait_cnt(input logic [15:0] v);
    int i;
    for (i = 0; i < 2000 && cnt !== v; i++) @(negedge core_clk_i);
    chk("count", v, cnt);
  endtask : wait_cnt

  task automatic ovf_win(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge core_clk_i);
      if (ovf === 1'b1) k++;
    end
  endtask : ovf_win

  // Fresh start in a given mode with the three output fields
  task automatic setup(input logic [3:0] mode, input logic [5:0] chans);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    hib <= mode[3:2];
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    reg_wr(`TWM_CTRL_A_ADDR, {chans, mode[1:0]});
  endtask : setup

  task automatic t_regs;
    logic [7:0] d;
    reg_rd(`TWM_CTRL_A_ADDR, d);
    chk("ctrl_a reset", {8'h00, `TWM_CTRL_A_RST}, {8'h00, d});
    reg_wr(`TWM_CTRL_A_ADDR, 8'hA5);
    reg_rd(`TWM_CTRL_A_ADDR, d);
    chk("ctrl_a", 16'h00A5, {8'h00, d});
    reg_rd(8'h8A, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    $display("test regs done");
  endtask : t_regs

  task automatic t_fast;
    int k;
    pdata <= 3'b100;
    setup(`TWM_MODE_FAST8, 6'b101101);
    wait_cnt(16'h0080);
    wait_cnt(16'h0020);
    chk("pin a", 16'h0001, {15'h0000, lvl[0]});
    chk("pin b", 16'h0000, {15'h0000, lvl[1]});
    chk("pin c port", 16'h0001, {15'h0000, lvl[2]});
    wait_cnt(16'h0060);
    chk("pin a", 16'h0000, {15'h0000, lvl[0]});
    chk("pin b", 16'h0001, {15'h0000, lvl[1]});
    wait_cnt(16'h00FC);
    ovf_win(6, k);
    chk("ovf at top", 16'h0001, k[15:0]);
    chk("wrap", 16'h0002, cnt);
    @(posedge core_clk_i);
    tick <= 1'b0;
    // The tick taken at the edge that lowers it still counts, so the counter rests at 3
    repeat (6) @(negedge core_clk_i);
    chk("held", 16'h0003, cnt);
    @(posedge core_clk_i);
    tick <= 1'b1;
    cmp_a <= `TWM_TOP_8BIT;
    wait_cnt(16'h0080);
    wait_cnt(16'h0001);
    wait_cnt(16'h0080);
    wait_cnt(16'h0001);
    chk("pin a top", 16'h0001, {15'h0000, lvl[0]});
    cmp_a <= 16'h0040;
    $display("test fast done");
  endtask : t_fast

  task automatic t_phase;
    int k;
    pdata <= 3'b000;
    setup(`TWM_MODE_PC8, 6'b101110);
    wait_cnt(`TWM_TOP_8BIT);
    wait_cnt(16'h0020);
    chk("down", 16'h0000, {15'h0000, up});
    chk("pin a", 16'h0001, {15'h0000, lvl[0]});
    chk("pin b", 16'h0000, {15'h0000, lvl[1]});
    chk("pin c", 16'h0001, {15'h0000, lvl[2]});
    wait_cnt(16'h0002);
    ovf_win(6, k);
    chk("ovf at bottom", 16'h0001, k[15:0]);
    chk("up", 16'h0001, {15'h0000, up});
    wait_cnt(16'h0060);
    chk("pin a", 16'h0000, {15'h0000, lvl[0]});
    chk("pin b", 16'h0001, {15'h0000, lvl[1]});
    $display("test phase done");
  endtask : t_phase

  // Phase and frequency correct with TOP from compare A; compare and flag move at BOTTOM
  task automatic t_pfc;
    int k;
    @(posedge core_clk_i);
    cmp_a <= 16'h0020;
    cmp_b <= 16'h0010;
    pdata <= 3'b100;
    setup(`TWM_MODE_PFC_OCA, 6'b011001);
    wait_cnt(16'h0018);
    // A new compare B must not act before the next BOTTOM
    @(posedge core_clk_i);
    cmp_b <= 16'h0004;
    wait_cnt(16'h000C);
    chk("pin b down", 16'h0001, {15'h0000, lvl[1]});
    chk("pin a", 16'h0001, {15'h0000, lvl[0]});
    chk("pin c port", 16'h0001, {15'h0000, lvl[2]});
    wait_cnt(16'h0000);
    ovf_win(3, k);
    chk("ovf at bottom", 16'h0001, k[15:0]);
    wait_cnt(16'h0008);
    chk("pin b new cmp", 16'h0000, {15'h0000, lvl[1]});
    wait_cnt(16'h001C);
    wait_cnt(16'h0010);
    chk("pin a", 16'h0000, {15'h0000, lvl[0]});
    $display("test pfc done");
  endtask : t_pfc

  task automatic t_ctc;
    logic a0;
    cmp_a <= 16'h0010;
    cmp_b <= 16'h0005;
    cmp_c <= 16'h0005;
    pdata <= 3'b011;
    setup(`TWM_MODE_CTC_OCA, 6'b011011);
    wait_cnt(16'h0010);
    @(negedge core_clk_i);
    chk("clear at cmp a", 16'h0000, cnt);
    wait_cnt(16'h0008);
    a0 = lvl[0];
    wait_cnt(16'h000F);
    wait_cnt(16'h0008);
    chk("toggle a", {15'h0000, ~a0}, {15'h0000, lvl[0]});
    chk("clear b", 16'h0000, {15'h0000, lvl[1]});
    chk("set c", 16'h0001, {15'h0000, lvl[2]});
    @(posedge core_clk_i);
    pdir <= 3'b010;
    @(negedge core_clk_i);
    chk("oe", 16'h0002, {13'h0000, oe});
    @(posedge core_clk_i);
    pdir <= 3'b111;
    cmp_a <= 16'h0040;
    cmp_b <= 16'h0040;
    cmp_c <= 16'h0040;
    $display("test ctc done");
  endtask : t_ctc

  task automatic t_rsvd;
    int k;
    pdata <= 3'b001;
    setup(`TWM_MODE_RSVD, 6'b100000);
    // Two ticks in mode 12 before the write lands, then the counter stops
    repeat (3) @(negedge core_clk_i);
    ovf_win(8, k);
    chk("stopped", 16'h0002, cnt);
    chk("no ovf", 16'h0000, k[15:0]);
    chk("pin a port", 16'h0001, {15'h0000, lvl[0]});
    $display("test reserved done");
  endtask : t_rsvd

  // Normal mode: one full run up to MAX, slow but the only way to reach the wrap
  task automatic t_normal;
    int i;
    int k;
    setup(`TWM_MODE_NORMAL, 6'b000100);
    for (i = 0; i < 70000 && cnt !== 16'hFFFE; i++) @(negedge core_clk_i);
    chk("count", 16'hFFFE, cnt);
    chk("pin b toggle", 16'h0001, {15'h0000, lvl[1]});
    ovf_win(4, k);
    chk("ovf at max", 16'h0001, k[15:0]);
    chk("wrap", 16'h0002, cnt);
    $display("test normal done");
  endtask : t_normal

  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_fast();
    t_phase();
    t_pfc();
    t_ctc();
    t_rsvd();
    t_normal();
    conclude();
  end
endmodule : twm_wave_ctrl_tb
